// File: rtl/bcod_decoder.sv
/*
  Opcode decoder with operand fetch and machine-cycle timing.
  Assumes program memory answers a fetch request with valid data one
  clock later; the mode strap is a pin and is synchronised here.
*/
// Function
// RQ1: Fetch 8-bit opcode, decode operation and length
// RQ2: Instructions are one, two or three bytes
// RQ3: Low three bits select banked working register
// RQ4: Direct address below 128 RAM, else special register
// RQ5: Opcode bit zero picks indirect pointer register
// RQ6: Immediate byte follows the opcode
// RQ7: Immediate word in the two following bytes
// RQ8: Long target is a full 16-bit address
// RQ9: Page target stays in next instruction's page
// RQ10: Relative offset signed, added to next address
// RQ11: Bit operand in RAM or special register space
// RQ12: Add rows 2x, 3x, 9x by low nibble
// RQ13: Logic rows 4x, 5x, 6x by low nibble
// RQ14: Increment, decrement, pointer increment, accumulator loads
// RQ15: Single-byte accumulator operations decoded exactly
// RQ16: Slow mode clocks 12, 24 or 48
// RQ17: Fast mode takes half the slow count
// RQ18: Machine cycle twelve clocks at 1, six at 0
// RQ19: One fetch request and PC step per operand
`timescale 1ns/1ps
module bcod_decoder (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Mode strap pin: 1 slow, 0 fast
  input wire logic i_fast_cycle_select,
  // Program memory
  input wire logic [7:0] i_pmem_data,
  output logic o_pmem_req,
  output logic [15:0] o_pmem_addr,
  // Decoded instruction
  output logic o_instr_valid,
  output logic [7:0] o_opcode,
  output logic [4:0] o_op_class,
  output logic [3:0] o_form,
  output logic [1:0] o_length,
  output logic [2:0] o_reg_sel,
  output logic o_ptr_sel,
  output logic o_direct_is_special,
  output logic [7:0] o_operand1,
  output logic [7:0] o_operand2,
  output logic [15:0] o_target,
  output logic [5:0] o_clocks,
  output logic o_busy
);

  typedef struct packed {
    bcod_pkg::bcod_op_e op;
    bcod_pkg::bcod_form_e form;
    logic [1:0] len;
    logic [2:0] mcs;
  } bcod_dec_s;

  // Decoding table used by both the fetch control and the latch
  function automatic bcod_dec_s bcod_decode(input logic [7:0] opc);
    bcod_dec_s d;
    logic [3:0] hi;
    logic [3:0] lo;
    d = '{op: bcod_pkg::BCOD_OP_OTHER, form: bcod_pkg::BCOD_FORM_NONE, len: 2'h1, mcs: bcod_pkg::MC_ONE};
    hi = opc[7:4];
    lo = opc[3:0];
    case (hi)
      bcod_pkg::ROW_ADD: d.op = bcod_pkg::BCOD_OP_ADD; // RQ12
      bcod_pkg::ROW_ADDC: d.op = bcod_pkg::BCOD_OP_ADDC;
      bcod_pkg::ROW_SUBB: d.op = bcod_pkg::BCOD_OP_SUBB;
      bcod_pkg::ROW_ORL: d.op = bcod_pkg::BCOD_OP_ORL; // RQ13
      bcod_pkg::ROW_ANL: d.op = bcod_pkg::BCOD_OP_ANL;
      bcod_pkg::ROW_XRL: d.op = bcod_pkg::BCOD_OP_XRL;
      bcod_pkg::ROW_INC: d.op = bcod_pkg::BCOD_OP_INC; // RQ14
      bcod_pkg::ROW_DEC: d.op = bcod_pkg::BCOD_OP_DEC;
      bcod_pkg::ROW_MOVA: d.op = bcod_pkg::BCOD_OP_MOV_A;
      default: d.op = bcod_pkg::BCOD_OP_OTHER;
    endcase
    if (d.op != bcod_pkg::BCOD_OP_OTHER) begin
      if (lo[3]) begin
        d.form = bcod_pkg::BCOD_FORM_REG; // RQ3
      end else if (lo[3:1] == 3'h3) begin
        d.form = bcod_pkg::BCOD_FORM_IND; // RQ5
      end else if (lo == bcod_pkg::LN_DIR) begin
        d.form = bcod_pkg::BCOD_FORM_DIR; // RQ4
        d.len = 2'h2;
      end else if (lo == bcod_pkg::LN_IMM && hi != bcod_pkg::ROW_INC && hi != bcod_pkg::ROW_DEC
                   && hi != bcod_pkg::ROW_MOVA) begin
        d.form = bcod_pkg::BCOD_FORM_IMM; // RQ6
        d.len = 2'h2;
      end else if (lo == bcod_pkg::LN_IMM && (hi == bcod_pkg::ROW_INC || hi == bcod_pkg::ROW_DEC)) begin
        d.form = bcod_pkg::BCOD_FORM_ACC;
      end else if (lo == bcod_pkg::LN_DIR_ACC && hi >= bcod_pkg::ROW_ORL && hi <= bcod_pkg::ROW_XRL) begin
        d.form = bcod_pkg::BCOD_FORM_DIR;
        d.len = 2'h2;
      end else if (lo == bcod_pkg::LN_DIR_IMM && hi >= bcod_pkg::ROW_ORL && hi <= bcod_pkg::ROW_XRL) begin
        d.form = bcod_pkg::BCOD_FORM_DIR_IMM; // RQ2
        d.len = 2'h3;
        d.mcs = bcod_pkg::MC_TWO; // RQ16
      end else begin
        d.op = bcod_pkg::BCOD_OP_OTHER;
      end
    end
    // Single-byte, word-load and jump opcodes override the row table
    case (opc)
      bcod_pkg::OP_NOP: d = '{op: bcod_pkg::BCOD_OP_NOP, form: bcod_pkg::BCOD_FORM_NONE,
                              len: 2'h1, mcs: bcod_pkg::MC_ONE}; // RQ15
      bcod_pkg::OP_RL: d = '{op: bcod_pkg::BCOD_OP_RL, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_RLC: d = '{op: bcod_pkg::BCOD_OP_RLC, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_RR: d = '{op: bcod_pkg::BCOD_OP_RR, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_RRC: d = '{op: bcod_pkg::BCOD_OP_RRC, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_SWAP: d = '{op: bcod_pkg::BCOD_OP_SWAP, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_CLR: d = '{op: bcod_pkg::BCOD_OP_CLR, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_CPL: d = '{op: bcod_pkg::BCOD_OP_CPL, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_DA: d = '{op: bcod_pkg::BCOD_OP_DA, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_ONE};
      bcod_pkg::OP_MUL: d = '{op: bcod_pkg::BCOD_OP_MUL, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_FOUR};
      bcod_pkg::OP_DIV: d = '{op: bcod_pkg::BCOD_OP_DIV, form: bcod_pkg::BCOD_FORM_ACC, len: 2'h1, mcs: bcod_pkg::MC_FOUR};
      bcod_pkg::OP_INC_DPW: d = '{op: bcod_pkg::BCOD_OP_INC_DPW, form: bcod_pkg::BCOD_FORM_NONE,
                                  len: 2'h1, mcs: bcod_pkg::MC_TWO}; // RQ14
      bcod_pkg::OP_MOV_DPW: d = '{op: bcod_pkg::BCOD_OP_OTHER, form: bcod_pkg::BCOD_FORM_WORD,
                                  len: 2'h3, mcs: bcod_pkg::MC_TWO}; // RQ7
      bcod_pkg::OP_LJMP, bcod_pkg::OP_LCALL: d = '{op: bcod_pkg::BCOD_OP_JUMP, form: bcod_pkg::BCOD_FORM_LONG,
                                                   len: 2'h3, mcs: bcod_pkg::MC_TWO}; // RQ8
      bcod_pkg::OP_SJMP: d = '{op: bcod_pkg::BCOD_OP_JUMP, form: bcod_pkg::BCOD_FORM_REL,
                               len: 2'h2, mcs: bcod_pkg::MC_TWO}; // RQ10
      default: begin
        if (opc[4:0] == bcod_pkg::OP_PAGE_LOW) begin
          d = '{op: bcod_pkg::BCOD_OP_JUMP, form: bcod_pkg::BCOD_FORM_PAGE, len: 2'h2, mcs: bcod_pkg::MC_TWO}; // RQ9
        end
      end
    endcase
    // Bit-clear/set/complement carry a bit address
    if (opc[3:0] == bcod_pkg::OP_BIT_LOW && opc[7:4] >= 4'hB && opc[7:4] <= 4'hD) begin
      d = '{op: bcod_pkg::BCOD_OP_OTHER, form: bcod_pkg::BCOD_FORM_BIT, len: 2'h2, mcs: bcod_pkg::MC_ONE}; // RQ11
    end
    return d;
  endfunction

  bcod_pkg::bcod_state_e state;
  bcod_dec_s dec;
  logic fast_meta;
  logic fast_sync;
  logic mc_tick;
  logic restart;
  logic [1:0] bytes_left;
  logic [2:0] mc_left;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic data_valid;

  assign dec = bcod_decode(i_pmem_data);
  assign next_pc = pc + 16'h0001;
  assign restart = (state == bcod_pkg::BCOD_ST_DONE);

  // Strap crosses in from a pin
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      fast_meta <= 1'b1;
      fast_sync <= 1'b1;
    end else begin
      fast_meta <= i_fast_cycle_select;
      fast_sync <= fast_meta;
    end
  end

  bcod_mc_timer u_mc_timer (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_fast(!fast_sync), // RQ18
    .i_restart(restart),
    .o_mc_tick(mc_tick)
  );

  // Fetch request is registered; data is valid the clock after
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      data_valid <= 1'b0;
    end else begin
      data_valid <= o_pmem_req;
    end
  end

  // Sequencer, program counter and fetch requests
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= bcod_pkg::BCOD_ST_OPCODE;
      pc <= 16'h0000;
      o_pmem_req <= 1'b0;
      o_pmem_addr <= 16'h0000;
      bytes_left <= 2'h0;
      mc_left <= 3'h0;
    end else begin
      o_pmem_req <= 1'b0;
      case (state)
        bcod_pkg::BCOD_ST_OPCODE: begin
          if (!o_pmem_req && !data_valid) begin
            o_pmem_req <= 1'b1; // RQ1
            o_pmem_addr <= pc;
            pc <= next_pc;
          end else if (data_valid) begin
            bytes_left <= dec.len - 2'h1;
            mc_left <= dec.mcs;
            if (dec.len != 2'h1) begin
              o_pmem_req <= 1'b1; // RQ19
              o_pmem_addr <= pc;
              pc <= next_pc;
              state <= bcod_pkg::BCOD_ST_OPERAND;
            end else begin
              state <= bcod_pkg::BCOD_ST_EXEC;
            end
          end
        end
        bcod_pkg::BCOD_ST_OPERAND: begin
          if (data_valid) begin
            bytes_left <= bytes_left - 2'h1;
            if (bytes_left == 2'h1) begin
              state <= bcod_pkg::BCOD_ST_EXEC;
            end else begin
              o_pmem_req <= 1'b1; // RQ19
              o_pmem_addr <= pc;
              pc <= next_pc;
            end
          end
        end
        bcod_pkg::BCOD_ST_EXEC: begin
          if (mc_tick) begin
            mc_left <= mc_left - 3'h1;
            if (mc_left == 3'h1) begin
              state <= bcod_pkg::BCOD_ST_DONE; // RQ16
            end
          end
        end
        bcod_pkg::BCOD_ST_DONE: begin
          state <= bcod_pkg::BCOD_ST_OPCODE;
        end
        default: state <= bcod_pkg::BCOD_ST_OPCODE;
      endcase
    end
  end

  // Latched decode of the opcode byte
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_opcode <= 8'h00;
      o_op_class <= 5'h00;
      o_form <= 4'h0;
      o_length <= 2'h0;
      o_reg_sel <= 3'h0;
      o_ptr_sel <= 1'b0;
      o_clocks <= 6'h00;
    end else if (state == bcod_pkg::BCOD_ST_OPCODE && data_valid) begin
      o_opcode <= i_pmem_data;
      o_op_class <= dec.op;
      o_form <= dec.form;
      o_length <= dec.len; // RQ2
      o_reg_sel <= i_pmem_data[bcod_pkg::REG_SEL_LSB +: 3]; // RQ3
      o_ptr_sel <= i_pmem_data[bcod_pkg::PTR_SEL_BIT]; // RQ5
      // Fast mode halves the slow count
      o_clocks <= 6'((fast_sync ? bcod_pkg::CLKS_PER_MC_SLOW : bcod_pkg::CLKS_PER_MC_FAST) * dec.mcs); // RQ17
    end
  end

  // Operand bytes and resolved targets
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_operand1 <= 8'h00;
      o_operand2 <= 8'h00;
      o_target <= 16'h0000;
      o_direct_is_special <= 1'b0;
    end else if (state == bcod_pkg::BCOD_ST_OPERAND && data_valid) begin
      if (bytes_left == o_length - 2'h1) begin
        o_operand1 <= i_pmem_data; // RQ6
        o_direct_is_special <= i_pmem_data[bcod_pkg::DIRECT_SPECIAL_BIT]; // RQ4
        // pc already points at the next instruction's first byte here for two-byte forms; for three-byte forms it points at the second operand byte
        if (o_form == bcod_pkg::BCOD_FORM_PAGE) begin
          o_target <= {pc[15:11], o_opcode[7:5], i_pmem_data}; // RQ9
        end else if (o_form == bcod_pkg::BCOD_FORM_REL) begin
          o_target <= pc + {{8{i_pmem_data[7]}}, i_pmem_data}; // RQ10
        end
      end else begin
        o_operand2 <= i_pmem_data;
        if (o_form == bcod_pkg::BCOD_FORM_LONG || o_form == bcod_pkg::BCOD_FORM_WORD) begin
          o_target <= {o_operand1, i_pmem_data}; // RQ8
        end
      end
    end
  end

  // Status outputs
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_instr_valid <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_instr_valid <= (state == bcod_pkg::BCOD_ST_DONE);
      o_busy <= (state == bcod_pkg::BCOD_ST_EXEC);
    end
  end

  sequence s_mul_seen;
    o_instr_valid && o_op_class == 5'h0A;
  endsequence

  AST_LEN_RANGE: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ2
    o_instr_valid |-> (o_length >= 2'h1 && o_length <= 2'h3))
    else $error("Length out of range");
  AST_MUL_CLOCKS: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ16
    s_mul_seen |-> (o_clocks == (fast_sync ? 6'h30 : 6'h18)))
    else $error("Multiply clock count wrong");
  AST_REG_SEL: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ3
    o_instr_valid && o_form == 4'h1 |-> o_reg_sel == o_opcode[2:0])
    else $error("Register select mismatch");
  AST_PTR_SEL: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ5
    o_instr_valid && o_form == 4'h2 |-> o_ptr_sel == o_opcode[0])
    else $error("Pointer select mismatch");
  AST_DIRECT_SPACE: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ4
    o_instr_valid && o_form == 4'h3 |-> o_direct_is_special == o_operand1[7])
    else $error("Direct space mismatch");
  AST_FAST_HALF: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ17
    o_instr_valid && !fast_sync |-> (o_clocks == 6'h06 || o_clocks == 6'h0C || o_clocks == 6'h18))
    else $error("Fast count not halved");
  AST_PC_STEP: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ19
    o_pmem_req |-> pc == $past(pc) + 16'h0001)
    else $error("PC did not step with fetch");
  AST_ONE_BYTE: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ15
    o_instr_valid && o_opcode == 8'hC4 |-> o_length == 2'h1 && o_op_class == 5'h13)
    else $error("Swap decoded wrong");
  AST_DONE_VALID: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ1
    state == bcod_pkg::BCOD_ST_DONE |=> o_instr_valid ##1 !o_instr_valid)
    else $error("Valid pulse wrong");

endmodule

// File: rtl/bcod_pkg.sv
/*
  Shared constants and types for the opcode decoder: opcode fields,
  operand forms, operation classes and machine-cycle clock counts.
  Assumes one 40 MHz clock and an asynchronous active-low reset.
*/
package bcod_pkg;

  localparam int CLK_PERIOD_NS = 25;

  // Clocks per machine cycle in each mode
  localparam logic [5:0] CLKS_PER_MC_SLOW = 6'h0C;
  localparam logic [5:0] CLKS_PER_MC_FAST = 6'h06;

  // Machine cycles per instruction class
  localparam logic [2:0] MC_ONE = 3'h1;
  localparam logic [2:0] MC_TWO = 3'h2;
  localparam logic [2:0] MC_FOUR = 3'h4;

  // Opcode field positions
  localparam int REG_SEL_LSB = 0;
  localparam int PTR_SEL_BIT = 0;
  localparam int DIRECT_SPECIAL_BIT = 7;

  // Low-nibble codes of the arithmetic and logic rows
  localparam logic [3:0] LN_DIR_ACC = 4'h2;
  localparam logic [3:0] LN_DIR_IMM = 4'h3;
  localparam logic [3:0] LN_IMM = 4'h4;
  localparam logic [3:0] LN_DIR = 4'h5;

  // Row bases (high nibble)
  localparam logic [3:0] ROW_INC = 4'h0;
  localparam logic [3:0] ROW_DEC = 4'h1;
  localparam logic [3:0] ROW_ADD = 4'h2;
  localparam logic [3:0] ROW_ADDC = 4'h3;
  localparam logic [3:0] ROW_ORL = 4'h4;
  localparam logic [3:0] ROW_ANL = 4'h5;
  localparam logic [3:0] ROW_XRL = 4'h6;
  localparam logic [3:0] ROW_SUBB = 4'h9;
  localparam logic [3:0] ROW_MOVA = 4'hE;

  // Individual opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_RR = 8'h03;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_RL = 8'h23;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_INC_DPW = 8'hA3;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_DA = 8'hD4;
  localparam logic [7:0] OP_CLR = 8'hE4;
  localparam logic [7:0] OP_CPL = 8'hF4;
  localparam logic [7:0] OP_MOV_DPW = 8'h90;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [4:0] OP_PAGE_LOW = 5'h01;
  localparam logic [3:0] OP_BIT_LOW = 4'h2;

  // Operand forms
  typedef enum logic [3:0] {
    BCOD_FORM_NONE = 4'h0,
    BCOD_FORM_REG = 4'h1,
    BCOD_FORM_IND = 4'h2,
    BCOD_FORM_DIR = 4'h3,
    BCOD_FORM_IMM = 4'h4,
    BCOD_FORM_DIR_IMM = 4'h5,
    BCOD_FORM_WORD = 4'h6,
    BCOD_FORM_LONG = 4'h7,
    BCOD_FORM_PAGE = 4'h8,
    BCOD_FORM_REL = 4'h9,
    BCOD_FORM_BIT = 4'hA,
    BCOD_FORM_ACC = 4'hB
  } bcod_form_e;

  // Operation classes
  typedef enum logic [4:0] {
    BCOD_OP_NOP = 5'h00,
    BCOD_OP_ADD = 5'h01,
    BCOD_OP_ADDC = 5'h02,
    BCOD_OP_SUBB = 5'h03,
    BCOD_OP_ORL = 5'h04,
    BCOD_OP_ANL = 5'h05,
    BCOD_OP_XRL = 5'h06,
    BCOD_OP_INC = 5'h07,
    BCOD_OP_DEC = 5'h08,
    BCOD_OP_INC_DPW = 5'h09,
    BCOD_OP_MUL = 5'h0A,
    BCOD_OP_DIV = 5'h0B,
    BCOD_OP_DA = 5'h0C,
    BCOD_OP_CLR = 5'h0D,
    BCOD_OP_CPL = 5'h0E,
    BCOD_OP_RL = 5'h0F,
    BCOD_OP_RLC = 5'h10,
    BCOD_OP_RR = 5'h11,
    BCOD_OP_RRC = 5'h12,
    BCOD_OP_SWAP = 5'h13,
    BCOD_OP_MOV_A = 5'h14,
    BCOD_OP_JUMP = 5'h15,
    BCOD_OP_OTHER = 5'h1F
  } bcod_op_e;

  // Fetch/execute states, one-hot
  typedef enum logic [3:0] {
    BCOD_ST_OPCODE = 4'b0001,
    BCOD_ST_OPERAND = 4'b0010,
    BCOD_ST_EXEC = 4'b0100,
    BCOD_ST_DONE = 4'b1000
  } bcod_state_e;

endpackage

// File: rtl/bcod_mc_timer.sv
/*
  Machine-cycle enable divider: a one-cycle pulse every 12 or 6 clocks.
  Assumes the mode input is steady; a change moves the wrap limit at once.
*/
`timescale 1ns/1ps
module bcod_mc_timer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Control
  input wire logic i_fast,
  input wire logic i_restart,
  // Enable
  output logic o_mc_tick
);

  logic [5:0] count;
  logic [5:0] limit;

  assign limit = i_fast ? bcod_pkg::CLKS_PER_MC_FAST : bcod_pkg::CLKS_PER_MC_SLOW;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= 6'h00;
      o_mc_tick <= 1'b0;
    end else if (i_restart) begin
      count <= 6'h01;
      o_mc_tick <= 1'b0;
    end else if (count >= limit - 6'h01) begin // RQ18
      count <= 6'h00;
      o_mc_tick <= 1'b1;
    end else begin
      count <= count + 6'h01;
      o_mc_tick <= 1'b0;
    end
  end

endmodule

// File: sim/bcod_pmem_model.sv
/*
  Program memory model: answers every fetch request with the addressed
  byte one clock later. Assumes one-cycle requests and a 256-byte image.
*/
`timescale 1ns/1ps
module bcod_pmem_model (
  // Clock
  input wire logic i_mclk,
  // Fetch
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_data
);
  logic [7:0] mem [0:255];

  initial o_data = 8'h00;

  // Stale bytes flip every cycle so a late or early sample cannot pass
  always @(posedge i_mclk) begin
    if (i_req === 1'b1) begin
      o_data <= #1 mem[i_addr[7:0]];
    end else begin
      o_data <= #1 ~o_data;
    end
  end
endmodule

// File: sim/byte_cpu_opcode_decoder_tb.sv
/*
  Self-checking bench for the opcode decoder and its memory model.
  Assumes program bytes are preloaded into the model before each reset.
*/
`timescale 1ns/1ps
module byte_cpu_opcode_decoder_tb;
  logic clk, rstn, fast, req, valid, ptr, spec, busy;
  logic [7:0] pdata, opc, op1, op2;
  logic [15:0] addr, target, pc;
  logic [4:0] cls;
  logic [3:0] form;
  logic [2:0] rsel;
  logic [1:0] len;
  logic [5:0] clks;
  logic [15:0] alog [0:63];
  int err_total, samples_checked, req_cnt, base, cyc, last_t, iv;

  initial clk = 1'b0;
  always #(bcod_pkg::CLK_PERIOD_NS / 2.0) clk = ~clk;

  bcod_decoder u_bcod_decoder (.i_mclk(clk), .i_resetn(rstn), .i_fast_cycle_select(fast),
    .i_pmem_data(pdata), .o_pmem_req(req), .o_pmem_addr(addr), .o_instr_valid(valid),
    .o_opcode(opc), .o_op_class(cls), .o_form(form), .o_length(len), .o_reg_sel(rsel),
    .o_ptr_sel(ptr), .o_direct_is_special(spec), .o_operand1(op1), .o_operand2(op2),
    .o_target(target), .o_clocks(clks), .o_busy(busy));

  bcod_pmem_model u_bcod_pmem_model (.i_mclk(clk), .i_req(req), .i_addr(addr), .o_data(pdata));

  // Logs every fetch address in order of request
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (rstn !== 1'b1) begin
      req_cnt = 0;
    end else if (req === 1'b1) begin
      alog[req_cnt[5:0]] = addr;
      req_cnt = req_cnt + 1;
    end
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic f, input logic [127:0] prog);
    rstn = 1'b0;
    fast = f;
    for (int i = 0; i < 16; i++)
      u_bcod_pmem_model.mem[i] = prog[127-8*i -: 8];
    repeat (10) tick;
    chk({req, valid, busy}, 16'h0000);
    rstn = 1'b1;
    base = 0;
    pc = 16'h0000;
    last_t = cyc;
    tick;
    chk(req, 16'h0001);
    chk(addr, 16'h0000);
  endtask

  // Mask bit 0 checks the form, bit 1 the class
  task automatic exp_ins(input logic [7:0] o, input logic [4:0] c, input logic [3:0] f,
    input logic [1:0] l, input logic [5:0] k, input logic [1:0] m);
    int n, nb;
    n = 0;
    nb = 0;
    do begin
      tick;
      n++;
      if (busy === 1'b1) nb++;
      if (n > 400) begin
        err_total++;
        tally_and_finish;
      end
    end while (valid !== 1'b1);
    iv = cyc - last_t;
    last_t = cyc;
    // Busy must have shown during execution and dropped by the valid pulse
    chk(16'({busy, nb != 0}), 16'h0001);
    chk(opc, o);
    if (m[1]) chk(cls, c);
    if (m[0]) chk(form, f);
    chk(len, l);
    chk(clks, k);
    chk(16'(req_cnt - base), l);
    for (int i = 0; i < l; i++)
      chk(alog[base+i], pc + 16'(i));
    base = req_cnt;
    pc = pc + l;
  endtask

  task automatic scen_arith;
    do_reset(1'b1, 128'h2455_2590_2627_2D35_7F94_019B_0000_0000);
    exp_ins(8'h24, bcod_pkg::BCOD_OP_ADD, bcod_pkg::BCOD_FORM_IMM, 2'h2, 6'h0C, 2'h3);
    chk(op1, 16'h0055);
    exp_ins(8'h25, bcod_pkg::BCOD_OP_ADD, bcod_pkg::BCOD_FORM_DIR, 2'h2, 6'h0C, 2'h3);
    chk(op1, 16'h0090);
    chk(spec, 16'h0001);
    exp_ins(8'h26, bcod_pkg::BCOD_OP_ADD, bcod_pkg::BCOD_FORM_IND, 2'h1, 6'h0C, 2'h3);
    chk(ptr, 16'h0000);
    exp_ins(8'h27, bcod_pkg::BCOD_OP_ADD, bcod_pkg::BCOD_FORM_IND, 2'h1, 6'h0C, 2'h3);
    chk(ptr, 16'h0001);
    exp_ins(8'h2D, bcod_pkg::BCOD_OP_ADD, bcod_pkg::BCOD_FORM_REG, 2'h1, 6'h0C, 2'h3);
    chk(rsel, 16'h0005);
    exp_ins(8'h35, bcod_pkg::BCOD_OP_ADDC, bcod_pkg::BCOD_FORM_DIR, 2'h2, 6'h0C, 2'h3);
    chk(spec, 16'h0000);
    exp_ins(8'h94, bcod_pkg::BCOD_OP_SUBB, bcod_pkg::BCOD_FORM_IMM, 2'h2, 6'h0C, 2'h3);
    chk(op1, 16'h0001);
    exp_ins(8'h9B, bcod_pkg::BCOD_OP_SUBB, bcod_pkg::BCOD_FORM_REG, 2'h1, 6'h0C, 2'h3);
    chk(rsel, 16'h0003);
  endtask

  task automatic scen_logic;
    do_reset(1'b1, 128'h4380_AA52_1044_0F55_2066_6FD2_8500_0000);
    exp_ins(8'h43, bcod_pkg::BCOD_OP_ORL, bcod_pkg::BCOD_FORM_DIR_IMM, 2'h3, 6'h18, 2'h3);
    chk(op2, 16'h00AA);
    chk(spec, 16'h0001);
    exp_ins(8'h52, bcod_pkg::BCOD_OP_ANL, bcod_pkg::BCOD_FORM_DIR, 2'h2, 6'h0C, 2'h3);
    chk(op1, 16'h0010);
    exp_ins(8'h44, bcod_pkg::BCOD_OP_ORL, bcod_pkg::BCOD_FORM_IMM, 2'h2, 6'h0C, 2'h3);
    exp_ins(8'h55, bcod_pkg::BCOD_OP_ANL, bcod_pkg::BCOD_FORM_DIR, 2'h2, 6'h0C, 2'h3);
    exp_ins(8'h66, bcod_pkg::BCOD_OP_XRL, bcod_pkg::BCOD_FORM_IND, 2'h1, 6'h0C, 2'h3);
    exp_ins(8'h6F, bcod_pkg::BCOD_OP_XRL, bcod_pkg::BCOD_FORM_REG, 2'h1, 6'h0C, 2'h3);
    chk(rsel, 16'h0007);
    exp_ins(8'hD2, 5'h00, bcod_pkg::BCOD_FORM_BIT, 2'h2, 6'h0C, 2'h1);
    chk(spec, 16'h0001);
  endtask

  task automatic scen_single;
    logic [7:0] ops [14] = '{8'h00, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hE4, 8'hF4, 8'hD4, 8'hA4,
      8'h84, 8'hA3, 8'h04, 8'h14};
    logic [4:0] cl [14] = '{bcod_pkg::BCOD_OP_NOP, bcod_pkg::BCOD_OP_RL, bcod_pkg::BCOD_OP_RLC,
      bcod_pkg::BCOD_OP_RR, bcod_pkg::BCOD_OP_RRC, bcod_pkg::BCOD_OP_SWAP, bcod_pkg::BCOD_OP_CLR,
      bcod_pkg::BCOD_OP_CPL, bcod_pkg::BCOD_OP_DA, bcod_pkg::BCOD_OP_MUL, bcod_pkg::BCOD_OP_DIV,
      bcod_pkg::BCOD_OP_INC_DPW, bcod_pkg::BCOD_OP_INC, bcod_pkg::BCOD_OP_DEC};
    int t;
    do_reset(1'b1, 128'h0023_3303_13C4_E4F4_D4A4_84A3_0414_E530);
    foreach (ops[i]) begin
      exp_ins(ops[i], cl[i], 4'h0, 2'h1, (ops[i] == 8'hA4 || ops[i] == 8'h84) ? 6'h30 :
        (ops[i] == 8'hA3) ? 6'h18 : 6'h0C, 2'h2);
      if (i == 8) t = iv;
      if (i == 9) chk(16'(iv - t), 16'h0024);
    end
    exp_ins(8'hE5, bcod_pkg::BCOD_OP_MOV_A, bcod_pkg::BCOD_FORM_DIR, 2'h2, 6'h0C, 2'h3);
    chk(op1, 16'h0030);
  endtask

  task automatic scen_fast;
    int t;
    do_reset(1'b0, 128'h0000_A424_11A3_4305_0684_0000_0000_0000);
    exp_ins(8'h00, bcod_pkg::BCOD_OP_NOP, 4'h0, 2'h1, 6'h06, 2'h2);
    exp_ins(8'h00, bcod_pkg::BCOD_OP_NOP, 4'h0, 2'h1, 6'h06, 2'h2);
    t = iv;
    exp_ins(8'hA4, bcod_pkg::BCOD_OP_MUL, 4'h0, 2'h1, 6'h18, 2'h2);
    chk(16'(iv - t), 16'h0012);
    exp_ins(8'h24, bcod_pkg::BCOD_OP_ADD, bcod_pkg::BCOD_FORM_IMM, 2'h2, 6'h06, 2'h3);
    exp_ins(8'hA3, bcod_pkg::BCOD_OP_INC_DPW, 4'h0, 2'h1, 6'h0C, 2'h2);
    exp_ins(8'h43, bcod_pkg::BCOD_OP_ORL, bcod_pkg::BCOD_FORM_DIR_IMM, 2'h3, 6'h0C, 2'h3);
    chk(op2, 16'h0006);
    exp_ins(8'h84, bcod_pkg::BCOD_OP_DIV, 4'h0, 2'h1, 6'h18, 2'h2);
  endtask

  // Each jump leaves the straight line, so each gets its own reset
  task automatic scen_jump;
    do_reset(1'b1, 128'h0080_8000_0000_0000_0000_0000_0000_0000);
    exp_ins(8'h00, bcod_pkg::BCOD_OP_NOP, 4'h0, 2'h1, 6'h0C, 2'h2);
    exp_ins(8'h80, bcod_pkg::BCOD_OP_JUMP, bcod_pkg::BCOD_FORM_REL, 2'h2, 6'h18, 2'h3);
    chk(target, 16'hFF83);
    do_reset(1'b1, 128'h90AB_CD02_1234_0000_0000_0000_0000_0000);
    exp_ins(8'h90, 5'h00, bcod_pkg::BCOD_FORM_WORD, 2'h3, 6'h18, 2'h1);
    chk({op1, op2}, 16'hABCD);
    exp_ins(8'h02, bcod_pkg::BCOD_OP_JUMP, bcod_pkg::BCOD_FORM_LONG, 2'h3, 6'h18, 2'h3);
    chk(target, 16'h1234);
    do_reset(1'b1, 128'hE155_0000_0000_0000_0000_0000_0000_0000);
    exp_ins(8'hE1, bcod_pkg::BCOD_OP_JUMP, bcod_pkg::BCOD_FORM_PAGE, 2'h2, 6'h18, 2'h3);
    chk(target, 16'h0755);
  endtask

  initial begin
    rstn = 1'b0;
    fast = 1'b1;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    for (int i = 0; i < 256; i++)
      u_bcod_pmem_model.mem[i] = 8'h00;
    scen_arith;
    scen_logic;
    scen_single;
    scen_fast;
    scen_jump;
    tally_and_finish;
  end
endmodule
